// ---- inc/vrcr_pkg.sv ----
// Summary of operation
// - one 8-bit read/write control register at F53h, all bits zero after reset.
// - bit 7 powers the reference circuit on when one, down when zero.
// - bit 6 connects the reference level to the shared analog pin when set.
// - with bit 6 set, the pin direction bit is ignored; pin is reference output.
// - bit 5 one gives low range (steps of 1/24), zero gives high range.
// - bit 4 one takes span from external reference pins, zero from analog supply.
// - bits 3..0 hold a level code 0..15 picking one of 16 levels.
// - high range output is one quarter span plus code times span over 32.
package vrcr_pkg;

	localparam int          REG_ADDR_W      = 12;
	localparam int          REG_DATA_W      = 8;
	localparam logic [11:0] CTRL_OFFSET     = 12'hF53;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

	localparam int          POWER_BIT       = 7;
	localparam int          PIN_OE_BIT      = 6;
	localparam int          RANGE_BIT       = 5;
	localparam int          SOURCE_BIT      = 4;
	localparam int          CODE_MSB        = 3;
	localparam int          CODE_LSB        = 0;
	localparam int          CODE_W          = 4;

	// level expressed in 96ths of the source span
	localparam int          LOW_DIV         = 24;
	localparam int          HIGH_DIV        = 32;
	localparam int          BASE_DIV        = 4;
	localparam int          LEVEL_DEN       = 96;
	localparam int          LOW_STEP        = LEVEL_DEN / LOW_DIV;
	localparam int          HIGH_STEP       = LEVEL_DEN / HIGH_DIV;
	localparam int          HIGH_BASE       = LEVEL_DEN / BASE_DIV;
	localparam int          LEVEL_W         = 7;

	typedef struct packed {
		logic                 power_en;
		logic                 pin_out_en;
		logic                 range_low;
		logic                 source_ext;
		logic [CODE_W-1:0]    level_code;
	} vrcr_ctrl_t;

	typedef struct packed {
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] wdata;
		logic                  wr;
		logic                  rd;
	} vrcr_req_t;

	function automatic logic [LEVEL_W-1:0] level_of(input vrcr_ctrl_t c);
		logic [LEVEL_W-1:0] lvl;
		lvl = '0;
		if (c.range_low)
			lvl = LEVEL_W'(int'(c.level_code) * LOW_STEP);
		else
			lvl = LEVEL_W'(HIGH_BASE + int'(c.level_code) * HIGH_STEP);
		return lvl;
	endfunction

endpackage

// ---- core/vrcr_level.sv ----
`timescale 1ns/1ns
module vrcr_level #(
	parameter int LEVEL_W = vrcr_pkg::LEVEL_W
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               load,
	input  wire vrcr_pkg::vrcr_ctrl_t ctrl_d,
	output logic [LEVEL_W-1:0]      level_q,
	output logic                    source_ext_q
);

	logic [LEVEL_W-1:0] level_d;

	// level in 96ths of span, range picks base and step
	always_comb
	begin
		level_d = LEVEL_W'(vrcr_pkg::level_of(ctrl_d));
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			level_q <= LEVEL_W'(vrcr_pkg::HIGH_BASE);
		else if (clk_en && load)
			level_q <= level_d;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			source_ext_q <= 1'b0;
		else if (clk_en && load)
			source_ext_q <= ctrl_d.source_ext;
	end

endmodule // vrcr_level

// ---- core/vrcr_top.sv ----
`timescale 1ns/1ns
module vrcr_top #(
	parameter int ADDR_W  = vrcr_pkg::REG_ADDR_W,
	parameter int DATA_W  = vrcr_pkg::REG_DATA_W,
	parameter int LEVEL_W = vrcr_pkg::LEVEL_W
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [DATA_W-1:0]       reg_rdata,
	input  wire logic               port_direction_bit,
	input  wire logic               port_out_data,
	input  wire logic               pin_i,
	output logic                    pin_o,
	output logic                    pin_oe,
	output logic                    pin_in_q,
	output vrcr_pkg::vrcr_ctrl_t    ref_ctrl,
	output logic                    reference_power_enable,
	output logic                    reference_pin_output_enable,
	output logic                    reference_range_select,
	output logic                    reference_source_select,
	output logic [3:0]              reference_level_code,
	output logic                    ref_pin_connect,
	output logic [LEVEL_W-1:0]      reference_output_level,
	output logic                    reference_source_ext
);

	vrcr_pkg::vrcr_req_t  req;
	vrcr_pkg::vrcr_ctrl_t ctrl_q;
	vrcr_pkg::vrcr_ctrl_t ctrl_d;
	logic                 wr_hit;
	logic                 rd_hit;
	logic [DATA_W-1:0]    rdata_q;
	logic                 pin_o_q;
	logic                 pin_in_sample_q;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(vrcr_pkg::CTRL_OFFSET);
	endfunction

	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;

	// register decode
	always_comb
	begin
		wr_hit = clk_en && req.wr && addr_hit(req.addr);
		rd_hit = clk_en && req.rd && addr_hit(req.addr);
	end

	// next control value, whole byte at once
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_hit)
			ctrl_d = vrcr_pkg::vrcr_ctrl_t'(req.wdata);
	end

	// control register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= vrcr_pkg::vrcr_ctrl_t'(vrcr_pkg::CTRL_RESET);
		else if (clk_en)
			ctrl_q <= ctrl_d;
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= vrcr_pkg::READ_UNMAPPED;
		else if (clk_en)
		begin
			if (rd_hit)
				rdata_q <= DATA_W'(ctrl_q);
			else
				rdata_q <= vrcr_pkg::READ_UNMAPPED;
		end
	end

	assign reg_rdata = rdata_q;

	// exported control fields
	always_comb
	begin
		ref_ctrl                    = ctrl_q;
		reference_power_enable      = ctrl_q.power_en;
		reference_pin_output_enable = ctrl_q.pin_out_en;
		reference_range_select      = ctrl_q.range_low;
		reference_source_select     = ctrl_q.source_ext;
		reference_level_code        = ctrl_q.level_code;
		ref_pin_connect             = ctrl_q.pin_out_en;
	end

	// digital pin driver, overridden by the reference output
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_o_q <= 1'b0;
		else if (clk_en)
			pin_o_q <= port_out_data;
	end

	always_comb
	begin
		pin_o  = pin_o_q;
		pin_oe = !port_direction_bit && !ctrl_q.pin_out_en;
	end

	// digital read of the pin, zero while pin is analog
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_in_sample_q <= 1'b0;
		else if (clk_en)
			pin_in_sample_q <= pin_i && !ctrl_q.pin_out_en;
	end

	assign pin_in_q = pin_in_sample_q;

	vrcr_level #(
		.LEVEL_W (LEVEL_W)
	) u_vrcr_level (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.clk_en       (clk_en),
		.load         (wr_hit),
		.ctrl_d       (ctrl_d),
		.level_q      (reference_output_level),
		.source_ext_q (reference_source_ext)
	);

	// checks
	sequence s_ctrl_write;
		clk_en && reg_wr && addr_hit(reg_addr);
	endsequence

	sequence s_oe_set_write;
		clk_en && reg_wr && addr_hit(reg_addr) && reg_wdata[vrcr_pkg::PIN_OE_BIT];
	endsequence

	sequence s_oe_clr_write;
		clk_en && reg_wr && addr_hit(reg_addr) && !reg_wdata[vrcr_pkg::PIN_OE_BIT];
	endsequence

	sequence s_ctrl_read;
		clk_en && reg_rd && addr_hit(reg_addr);
	endsequence

	property p_reset_clear;
		@(posedge ref_clk)
		$rose(rst_n) |-> (DATA_W'(ctrl_q) == vrcr_pkg::CTRL_RESET
			&& reg_rdata == vrcr_pkg::READ_UNMAPPED);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("control register not clear after reset");

	property p_write_all;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write |=> DATA_W'(ctrl_q) == $past(reg_wdata);
	endproperty
	a_write_all: assert property (p_write_all)
		else $error("write did not update all control bits");

	property p_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		!(clk_en && reg_wr && addr_hit(reg_addr)) |=> $stable(ctrl_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("control register changed without a write");

	property p_read_back;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write ##1 s_ctrl_read |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("read did not return written byte");

	property p_unmapped;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && !addr_hit(reg_addr) |=> reg_rdata == vrcr_pkg::READ_UNMAPPED;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_power;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write |=> reference_power_enable == $past(reg_wdata[vrcr_pkg::POWER_BIT]);
	endproperty
	a_power: assert property (p_power)
		else $error("power enable does not follow bit 7");

	property p_pin_connect;
		@(posedge ref_clk) disable iff (!rst_n)
		s_oe_set_write |=> ref_pin_connect && !pin_oe;
	endproperty
	a_pin_connect: assert property (p_pin_connect)
		else $error("reference not connected after set");

	property p_pin_release;
		@(posedge ref_clk) disable iff (!rst_n)
		s_oe_clr_write ##1 (!port_direction_bit) |-> pin_oe && !ref_pin_connect;
	endproperty
	a_pin_release: assert property (p_pin_release)
		else $error("pin not returned to port after clear");

	property p_override;
		@(posedge ref_clk) disable iff (!rst_n)
		ref_pin_connect |-> !pin_oe ##1 (!pin_in_q || !ref_pin_connect);
	endproperty
	a_override: assert property (p_override)
		else $error("port direction not overridden");

	property p_range_level;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write ##1 reference_range_select
			|-> reference_output_level
				== LEVEL_W'(int'(reference_level_code) * vrcr_pkg::LOW_STEP);
	endproperty
	a_range_level: assert property (p_range_level)
		else $error("low range level wrong");

	property p_high_level;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write ##1 !reference_range_select
			|-> reference_output_level == LEVEL_W'(vrcr_pkg::HIGH_BASE
				+ int'(reference_level_code) * vrcr_pkg::HIGH_STEP);
	endproperty
	a_high_level: assert property (p_high_level)
		else $error("high range level wrong");

	property p_source;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write |=> reference_source_ext == $past(reg_wdata[vrcr_pkg::SOURCE_BIT]);
	endproperty
	a_source: assert property (p_source)
		else $error("source select does not follow bit 4");

	property p_code;
		@(posedge ref_clk) disable iff (!rst_n)
		s_ctrl_write |=> reference_level_code == $past(reg_wdata[3:0]);
	endproperty
	a_code: assert property (p_code)
		else $error("level code does not follow bits 3..0");

	property p_freeze;
		@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(reference_output_level) && $stable(reg_rdata);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

endmodule // vrcr_top

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	logic                 ref_clk   = 1'b0;
	logic                 rst_n     = 1'b0;
	logic                 clk_en    = 1'b0;
	logic [11:0]          reg_addr  = 12'h000;
	logic [7:0]           reg_wdata = 8'h00;
	logic                 reg_wr    = 1'b0;
	logic                 reg_rd    = 1'b0;
	logic                 dir_bit   = 1'b1;
	logic                 out_data  = 1'b0;
	logic                 pin_i     = 1'b0;
	logic [7:0]           reg_rdata;
	logic                 pin_o;
	logic                 pin_oe;
	logic                 pin_in_q;
	vrcr_pkg::vrcr_ctrl_t ref_ctrl;
	logic                 pwr;
	logic                 poe;
	logic                 rng;
	logic                 src;
	logic [3:0]           code;
	logic                 conn;
	logic [6:0]           level;
	logic                 src_ext;
	int                   n_mismatch  = 0;
	int                   checks_done = 0;
	int                   cycles      = 0;

	always #10 ref_clk = ~ref_clk;

	vrcr_top u_vrcr_top (
		.ref_clk                     (ref_clk),
		.rst_n                       (rst_n),
		.clk_en                      (clk_en),
		.reg_addr                    (reg_addr),
		.reg_wdata                   (reg_wdata),
		.reg_wr                      (reg_wr),
		.reg_rd                      (reg_rd),
		.reg_rdata                   (reg_rdata),
		.port_direction_bit          (dir_bit),
		.port_out_data               (out_data),
		.pin_i                       (pin_i),
		.pin_o                       (pin_o),
		.pin_oe                      (pin_oe),
		.pin_in_q                    (pin_in_q),
		.ref_ctrl                    (ref_ctrl),
		.reference_power_enable      (pwr),
		.reference_pin_output_enable (poe),
		.reference_range_select      (rng),
		.reference_source_select     (src),
		.reference_level_code        (code),
		.ref_pin_connect             (conn),
		.reference_output_level      (level),
		.reference_source_ext        (src_ext)
	);

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_reset();
		logic [7:0] d;
		rd_reg(12'hF53, d);
		chk("reset readback", 8'h00, d);
		chk("reset ctrl", 8'h00, ref_ctrl);
		chk("reset level", 8'h18, {1'b0, level});
		$display("test reset done");
	endtask

	task automatic t_fields();
		logic [7:0] v [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0F, 8'hA5};
		logic [7:0] d;
		foreach (v[i])
		begin
			wr_reg(12'hF53, v[i]);
			chk("fields", v[i], {pwr, poe, rng, src, code});
			chk("ctrl", v[i], ref_ctrl);
			chk("connect", {7'h00, v[i][6]}, {7'h00, conn});
			chk("source ext", {7'h00, v[i][4]}, {7'h00, src_ext});
			rd_reg(12'hF53, d);
			chk("readback", v[i], d);
		end
		$display("test fields done");
	endtask

	task automatic t_level();
		logic [7:0] e;
		for (int r = 0; r < 2; r++)
			for (int c = 0; c < 16; c++)
			begin
				wr_reg(12'hF53, {2'b10, r[0], 1'b0, c[3:0]});
				e = r ? 8'(c * 4) : 8'(24 + c * 3);
				chk("level", e, {1'b0, level});
			end
		$display("test level done");
	endtask

	task automatic t_pin();
		dir_bit  <= 1'b0;
		out_data <= 1'b1;
		pin_i    <= 1'b1;
		wr_reg(12'hF53, 8'h00);
		@(posedge ref_clk);
		#1;
		chk("oe digital", 8'h01, {7'h00, pin_oe});
		chk("pin out", 8'h01, {7'h00, pin_o});
		chk("pin in", 8'h01, {7'h00, pin_in_q});
		wr_reg(12'hF53, 8'h40);
		@(posedge ref_clk);
		#1;
		chk("oe override", 8'h00, {7'h00, pin_oe});
		chk("pin in analog", 8'h00, {7'h00, pin_in_q});
		dir_bit <= 1'b1;
		$display("test pin done");
	endtask

	task automatic t_refuse();
		logic [7:0] d;
		wr_reg(12'hF53, 8'h55);
		wr_reg(12'hF52, 8'hAA);
		rd_reg(12'hF53, d);
		chk("unmapped write", 8'h55, d);
		rd_reg(12'hF52, d);
		chk("unmapped read", 8'h00, d);
		clk_en <= 1'b0;
		wr_reg(12'hF53, 8'hAA);
		clk_en <= 1'b1;
		rd_reg(12'hF53, d);
		chk("frozen write", 8'h55, d);
		// write then read with no gap
		reg_addr  <= 12'hF53;
		reg_wdata <= 8'h3C;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk("back to back read", 8'h3C, reg_rdata);
		$display("test refuse done");
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n  <= 1'b1;
		clk_en <= 1'b1;
		t_reset();
		t_fields();
		t_level();
		t_pin();
		t_refuse();
		wrap_up();
	end
endmodule // tb_top
